/* File: rtl/lmt_defs.svh */
// Offsets, field positions, reset values and timing counts of the line maintenance logic
`ifndef LMT_DEFS_SVH
`define LMT_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LMT_OFS_PATTERN_CLOCK_CTRL 5'h0D
`define LMT_OFS_LOOPBACK_CTRL 5'h0E
`define LMT_OFS_ERROR_COUNT_CTRL 5'h13
`define LMT_OFS_IRQ_MASK_FIRST 5'h14
`define LMT_OFS_IRQ_MASK_SECOND 5'h15
`define LMT_OFS_IRQ_EDGE_SELECT 5'h16
`define LMT_OFS_LIVE_STATUS_FIRST 5'h17
`define LMT_OFS_IRQ_STATUS_FIRST 5'h19
`define LMT_OFS_IRQ_STATUS_SECOND 5'h1A
`define LMT_OFS_ERROR_RESULT_A 5'h1B
`define LMT_OFS_ERROR_RESULT_B 5'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LMT_PCC_PATTERN_SELECT_LSB 0
`define LMT_PCC_PATTERN_CLOCK_SELECT 2
`define LMT_PCC_SEQUENCE_INVERT 3
`define LMT_LBC_ANALOG_LOOP 0
`define LMT_LBC_DIGITAL_LOOP 1
`define LMT_LBC_REMOTE_LOOP 2
`define LMT_ECC_ERROR_SELECT_LSB 0
`define LMT_ECC_COUNT_MODE 2
`define LMT_ECC_TRANSFER_REQUEST 3
`define LMT_ECC_ZERO_RUN_STANDARD 4
`define LMT_IRQ1_ERROR 0
`define LMT_IRQ1_OVERFLOW 1
`define LMT_IRQ1_TIMER 2
`define LMT_IRQ0_SEQUENCE_SYNC 0
`define LMT_LIVE_STATUS_FIRST_SEQUENCE_SYNC 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LMT_RST_CTRL 8'h00
`define LMT_RST_GEN_SEED 15'h7FFF

// ----------------------------------------------------------------
// Counts and timing
// ----------------------------------------------------------------
`define LMT_WINDOW_LAST 6'h3F
`define LMT_WINDOW_MAX_ERRORS 7'h06
`define LMT_EXZ_LIMIT_HDB3 8'h03
`define LMT_EXZ_LIMIT_ANSI 8'h0F
`define LMT_EXZ_LIMIT_FCC 8'h50
`define LMT_ONE_SECOND_MS 1000
`define LMT_CLK_PERIOD_NS 4
`define LMT_SECOND_CYCLES ((`LMT_ONE_SECOND_MS * 1000000) / `LMT_CLK_PERIOD_NS)

`endif

/* File: rtl/lmt_pkg.sv */
// Types shared by the line maintenance logic
package lmt_pkg;

  typedef struct packed {
    logic hw_mode;
    logic [1:0] pattern_select;
    logic [1:0] loop_select_pins;
    logic single_rail;
    logic hdb3;
  } lmt_hw_pins_s;

  typedef struct packed {
    logic clk;
    logic pos;
    logic neg;
  } lmt_rx_line_s;

  typedef struct packed {
    logic clk;
    logic data;
  } lmt_tx_in_s;

  typedef struct packed {
    logic [4:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } lmt_reg_req_s;

  typedef struct packed {
    lmt_hw_pins_s hw_s1;
    lmt_hw_pins_s hw_s2;
    lmt_rx_line_s rxl_s1;
    lmt_rx_line_s rxl_s2;
    logic rclk_prev;
    lmt_tx_in_s tx_s1;
    lmt_tx_in_s tx_s2;
    logic transmit_clock_prev;
    logic mclk_s1;
    logic mclk_s2;
    logic mclk_prev;
    logic [7:0] patt_ctrl;
    logic [7:0] loop_ctrl;
    logic [7:0] err_ctrl;
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [7:0] edge_sel;
    logic [7:0] irq0;
    logic [7:0] irq1;
    logic [15:0] result;
    logic [15:0] count;
    logic [31:0] sec_cnt;
    logic trf_prev;
    logic [14:0] gen;
    logic [14:0] chk;
    logic [5:0] win_bits;
    logic [6:0] win_errs;
    logic sync;
    logic seen_pulse;
    logic last_pol;
    logic seen_v;
    logic last_vpol;
    logic [7:0] zero_run;
    logic viol_pin;
    logic line_data;
    logic line_strobe;
    logic rx_data;
    logic rx_strobe;
    logic [7:0] rdata;
  } lmt_state_s;

endpackage : lmt_pkg

/* File: rtl/lmt_line_maint.sv */
// Line maintenance logic: test patterns, loopbacks, line code errors, error counter
//
// Summary of operation
// - Patterns run on transmit clock, or master clock when clock select is 1.
// - Clock select 0 and pattern select 00 passes transmit data unchanged.
// - Pattern select 01 sends continuous ones on the selected clock.
// - Clock select 1 with pattern select 00 sends continuous zeros.
// - Generate and check a 2^15-1 pseudo-random sequence.
// - Pattern select 10 sends the sequence, most significant bit first.
// - Sequence is sent plain or inverted per the invert bit.
// - Sync set at six or fewer errors per 64-bit window, cleared above.
// - Sync changes latch per edge select; interrupt when flag and enable set.
// - Error select 00 counts sequence bit errors in the 16-bit counter.
// - Analog loop returns transmit signal to receive outputs, line still driven.
// - Digital loop (bit or pins 10) returns transmit data to receive outputs.
// - Patterns may override transmit data during analog or digital loop.
// - Remote loop (bit or pins 11) sends recovered data to the transmitter.
// - AMI: two successive same-polarity pulses flag a bipolar violation.
// - HDB3: successive violations of same polarity flag a code violation.
// - Excess zeros: above 3 in HDB3; above 15 or 80 in AMI.
// - Only the selected error type counts; 11 counts violations and zeros.
// - Errors accumulate; error and overflow flags set, interrupts unless masked.
// - Single rail: violation pin high one receive clock period per violation.
// - Count mode 1: each second copy counter to results, restart counting.
// - Second expiry sets timer flag; interrupt if mask 0; cleared on read.
// - Count mode 0: copy and restart on rising edge of transfer request.
`timescale 1ns/1ps
`include "lmt_defs.svh"

module lmt_line_maint import lmt_pkg::*; #(
  parameter int P_SECOND_CYCLES = `LMT_SECOND_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_master_clock,
  input wire lmt_tx_in_s i_tx,
  input wire lmt_rx_line_s i_rx_line,
  input wire lmt_hw_pins_s i_hw,
  input wire lmt_reg_req_s i_reg,
  output logic [7:0] o_reg_rdata,
  output logic o_line_data,
  output logic o_line_strobe,
  output logic o_rx_data,
  output logic o_rx_strobe,
  output logic o_violation_flag_pin,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (P_SECOND_CYCLES < 2) begin : g_bad_second
    $error("P_SECOND_CYCLES must be at least 2");
  end

  localparam logic [31:0] SEC_LAST = 32'(P_SECOND_CYCLES - 1);

  function automatic logic [7:0] read_mux(input lmt_state_s s, input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `LMT_OFS_PATTERN_CLOCK_CTRL: v = s.patt_ctrl;
      `LMT_OFS_LOOPBACK_CTRL: v = s.loop_ctrl;
      `LMT_OFS_ERROR_COUNT_CTRL: v = s.err_ctrl;
      `LMT_OFS_IRQ_MASK_FIRST: v = s.mask0;
      `LMT_OFS_IRQ_MASK_SECOND: v = s.mask1;
      `LMT_OFS_IRQ_EDGE_SELECT: v = s.edge_sel;
      `LMT_OFS_LIVE_STATUS_FIRST: v = {7'h00, s.sync};
      `LMT_OFS_IRQ_STATUS_FIRST: v = s.irq0;
      `LMT_OFS_IRQ_STATUS_SECOND: v = s.irq1;
      `LMT_OFS_ERROR_RESULT_A: v = s.result[7:0];
      `LMT_OFS_ERROR_RESULT_B: v = s.result[15:8];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_mux

  lmt_state_s r_reg;
  lmt_state_s r_next;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    lmt_hw_pins_s hw;
    logic transmit_clock_tick;
    logic mclk_tick;
    logic rx_tick;
    logic [1:0] patt_sel;
    logic clk_sel;
    logic inv;
    logic analog_loop_enable;
    logic digital_loop_enable;
    logic remote_loop_enable;
    logic pulse;
    logic bipolar_violation;
    logic cv;
    logic viol;
    logic excess_zeros;
    logic [7:0] exz_limit;
    logic [7:0] zr_inc;
    logic line_tick;
    logic line_bit;
    logic chk_tick;
    logic chk_bit;
    logic chk_err;
    logic [6:0] win_total;
    logic new_sync;
    logic [1:0] inc;
    logic [16:0] sum;
    logic trf_now;
    logic expire;
    logic transfer;
    hw = r_reg.hw_s2;
    transmit_clock_tick = 1'b0;
    mclk_tick = 1'b0;
    rx_tick = 1'b0;
    patt_sel = 2'b00;
    clk_sel = 1'b0;
    inv = 1'b0;
    analog_loop_enable = 1'b0;
    digital_loop_enable = 1'b0;
    remote_loop_enable = 1'b0;
    pulse = 1'b0;
    bipolar_violation = 1'b0;
    cv = 1'b0;
    viol = 1'b0;
    excess_zeros = 1'b0;
    exz_limit = `LMT_EXZ_LIMIT_ANSI;
    zr_inc = 8'h00;
    line_tick = 1'b0;
    line_bit = 1'b0;
    chk_tick = 1'b0;
    chk_bit = 1'b0;
    chk_err = 1'b0;
    win_total = 7'h00;
    new_sync = 1'b0;
    inc = 2'b00;
    sum = 17'h00000;
    trf_now = 1'b0;
    expire = 1'b0;
    transfer = 1'b0;
    r_next = r_reg;

    // Pins from other clocks pass two flops before any logic reads them
    r_next.hw_s1 = i_hw;
    r_next.hw_s2 = r_reg.hw_s1;
    r_next.rxl_s1 = i_rx_line;
    r_next.rxl_s2 = r_reg.rxl_s1;
    r_next.rclk_prev = r_reg.rxl_s2.clk;
    r_next.tx_s1 = i_tx;
    r_next.tx_s2 = r_reg.tx_s1;
    r_next.transmit_clock_prev = r_reg.tx_s2.clk;
    r_next.mclk_s1 = i_master_clock;
    r_next.mclk_s2 = r_reg.mclk_s1;
    r_next.mclk_prev = r_reg.mclk_s2;
    transmit_clock_tick = r_reg.tx_s2.clk & ~r_reg.transmit_clock_prev;
    mclk_tick = r_reg.mclk_s2 & ~r_reg.mclk_prev;
    rx_tick = r_reg.rxl_s2.clk & ~r_reg.rclk_prev;

    // ----------------------------------------------------------------
    // Mode decode: hardware pins override register fields
    // ----------------------------------------------------------------
    patt_sel = hw.hw_mode ? hw.pattern_select :
      r_reg.patt_ctrl[`LMT_PCC_PATTERN_SELECT_LSB +: 2];
    clk_sel = ~hw.hw_mode & r_reg.patt_ctrl[`LMT_PCC_PATTERN_CLOCK_SELECT];
    inv = ~hw.hw_mode & r_reg.patt_ctrl[`LMT_PCC_SEQUENCE_INVERT];
    analog_loop_enable = ~hw.hw_mode & r_reg.loop_ctrl[`LMT_LBC_ANALOG_LOOP];
    digital_loop_enable = hw.hw_mode ? (hw.loop_select_pins == 2'b10) :
      r_reg.loop_ctrl[`LMT_LBC_DIGITAL_LOOP];
    remote_loop_enable = hw.hw_mode ? (hw.loop_select_pins == 2'b11) :
      r_reg.loop_ctrl[`LMT_LBC_REMOTE_LOOP];

    // ----------------------------------------------------------------
    // Receive line code checks
    // ----------------------------------------------------------------
    pulse = r_reg.rxl_s2.pos | r_reg.rxl_s2.neg;
    // same polarity as the previous pulse
    bipolar_violation = rx_tick & pulse & r_reg.seen_pulse & (r_reg.rxl_s2.pos == r_reg.last_pol);
    // violations in HDB3 must alternate; a repeat is a code violation
    cv = bipolar_violation & r_reg.seen_v & (r_reg.rxl_s2.pos == r_reg.last_vpol);
    viol = hw.hdb3 ? cv : bipolar_violation;
    if (rx_tick & pulse) begin
      r_next.seen_pulse = 1'b1;
      r_next.last_pol = r_reg.rxl_s2.pos;
    end
    if (bipolar_violation) begin
      r_next.seen_v = 1'b1;
      r_next.last_vpol = r_reg.rxl_s2.pos;
    end
    // zero run limit by coding and standard
    if (hw.hdb3) begin
      exz_limit = `LMT_EXZ_LIMIT_HDB3;
    end else if (~hw.hw_mode & r_reg.err_ctrl[`LMT_ECC_ZERO_RUN_STANDARD]) begin
      exz_limit = `LMT_EXZ_LIMIT_FCC;
    end else begin
      exz_limit = `LMT_EXZ_LIMIT_ANSI;
    end
    zr_inc = r_reg.zero_run + 8'h01;
    if (rx_tick) begin
      if (pulse) begin
        r_next.zero_run = 8'h00;
      end else if (r_reg.zero_run != 8'hFF) begin
        r_next.zero_run = zr_inc;
        // One flag per run, on the first zero past the limit
        excess_zeros = (zr_inc == exz_limit + 8'h01);
      end
    end
    // held for one receive clock period in single rail mode
    if (rx_tick) begin
      r_next.viol_pin = hw.single_rail & viol;
    end

    // ----------------------------------------------------------------
    // Transmit source selection
    // ----------------------------------------------------------------
    if (remote_loop_enable) begin
      line_tick = rx_tick;
      line_bit = pulse;
    end else if ((patt_sel != 2'b00) | clk_sel) begin
      line_tick = clk_sel ? mclk_tick : transmit_clock_tick;
      case (patt_sel)
        2'b00: line_bit = 1'b0;
        2'b01: line_bit = 1'b1;
        // sequence, oldest stage first, optional inversion
        2'b10: line_bit = r_reg.gen[14] ^ inv;
        default: line_bit = r_reg.tx_s2.data;
      endcase
    end else begin
      line_tick = transmit_clock_tick;
      line_bit = r_reg.tx_s2.data;
    end
    // generator steps only while the sequence is sent
    if (line_tick & ~remote_loop_enable & (patt_sel == 2'b10)) begin
      r_next.gen = {r_reg.gen[13:0], r_reg.gen[13] ^ r_reg.gen[14]};
    end
    r_next.line_strobe = line_tick;
    if (line_tick) begin
      r_next.line_data = line_bit;
    end

    // ----------------------------------------------------------------
    // Receive outputs and sequence checker
    // ----------------------------------------------------------------
    // loops feed the transmitted stream, patterns included
    if (analog_loop_enable | digital_loop_enable) begin
      chk_tick = line_tick;
      chk_bit = line_bit;
    end else begin
      chk_tick = rx_tick;
      chk_bit = pulse;
    end
    r_next.rx_strobe = chk_tick;
    if (chk_tick) begin
      r_next.rx_data = chk_bit;
    end
    // checker loads received bits, so it reseeds itself after slips
    chk_err = chk_tick & ((chk_bit ^ inv) != (r_reg.chk[13] ^ r_reg.chk[14]));
    if (chk_tick) begin
      r_next.chk = {r_reg.chk[13:0], chk_bit ^ inv};
      r_next.win_bits = r_reg.win_bits + 6'h01;
      win_total = r_reg.win_errs + {6'h00, chk_err};
      r_next.win_errs = win_total;
      // decision at the end of each 64-bit window
      if (r_reg.win_bits == `LMT_WINDOW_LAST) begin
        new_sync = (win_total <= `LMT_WINDOW_MAX_ERRORS);
        r_next.sync = new_sync;
        r_next.win_errs = 7'h00;
      end else begin
        new_sync = r_reg.sync;
      end
    end else begin
      new_sync = r_reg.sync;
    end

    // ----------------------------------------------------------------
    // Error counter and transfer
    // ----------------------------------------------------------------
    // error type selection
    case (r_reg.err_ctrl[`LMT_ECC_ERROR_SELECT_LSB +: 2])
      2'b00: inc = {1'b0, chk_err};
      2'b01: inc = {1'b0, viol};
      2'b10: inc = {1'b0, excess_zeros};
      default: inc = {1'b0, viol} + {1'b0, excess_zeros};
    endcase
    sum = {1'b0, r_reg.count} + {15'h0000, inc};
    trf_now = r_reg.err_ctrl[`LMT_ECC_TRANSFER_REQUEST];
    r_next.trf_prev = trf_now;
    if (r_reg.err_ctrl[`LMT_ECC_COUNT_MODE]) begin
      expire = (r_reg.sec_cnt == SEC_LAST);
      r_next.sec_cnt = expire ? 32'h00000000 : r_reg.sec_cnt + 32'h00000001;
      transfer = expire;
    end else begin
      r_next.sec_cnt = 32'h00000000;
      // rising edge of the transfer request
      transfer = trf_now & ~r_reg.trf_prev;
    end
    if (transfer) begin
      // errors in the copy cycle open the next period
      r_next.result = r_reg.count;
      r_next.count = {14'h0000, inc};
    end else begin
      r_next.count = sum[15:0];
    end

    // ----------------------------------------------------------------
    // Register writes, read data, read-clear then set (set wins)
    // ----------------------------------------------------------------
    if (i_reg.wr) begin
      case (i_reg.addr)
        `LMT_OFS_PATTERN_CLOCK_CTRL: r_next.patt_ctrl = i_reg.wdata;
        `LMT_OFS_LOOPBACK_CTRL: r_next.loop_ctrl = i_reg.wdata;
        `LMT_OFS_ERROR_COUNT_CTRL: r_next.err_ctrl = i_reg.wdata;
        `LMT_OFS_IRQ_MASK_FIRST: r_next.mask0 = i_reg.wdata;
        `LMT_OFS_IRQ_MASK_SECOND: r_next.mask1 = i_reg.wdata;
        `LMT_OFS_IRQ_EDGE_SELECT: r_next.edge_sel = i_reg.wdata;
        default: r_next.patt_ctrl = r_reg.patt_ctrl;
      endcase
    end
    if (i_reg.rd) begin
      r_next.rdata = read_mux(r_reg, i_reg.addr);
      // flags clear when their status register is read
      if (i_reg.addr == `LMT_OFS_IRQ_STATUS_FIRST) begin
        r_next.irq0 = 8'h00;
      end
      if (i_reg.addr == `LMT_OFS_IRQ_STATUS_SECOND) begin
        r_next.irq1 = 8'h00;
      end
    end
    // rising edge only, or any change when edge select is 1
    if ((new_sync & ~r_reg.sync) |
        (r_reg.edge_sel[`LMT_IRQ0_SEQUENCE_SYNC] & (new_sync != r_reg.sync))) begin
      r_next.irq0[`LMT_IRQ0_SEQUENCE_SYNC] = 1'b1;
    end
    if (inc != 2'b00) begin
      r_next.irq1[`LMT_IRQ1_ERROR] = 1'b1;
    end
    if (~transfer & sum[16]) begin
      r_next.irq1[`LMT_IRQ1_OVERFLOW] = 1'b1;
    end
    if (expire) begin
      r_next.irq1[`LMT_IRQ1_TIMER] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg <= '0;
      r_reg.patt_ctrl <= `LMT_RST_CTRL;
      r_reg.loop_ctrl <= `LMT_RST_CTRL;
      r_reg.err_ctrl <= `LMT_RST_CTRL;
      r_reg.mask0 <= `LMT_RST_CTRL;
      r_reg.mask1 <= `LMT_RST_CTRL;
      r_reg.edge_sel <= `LMT_RST_CTRL;
      r_reg.gen <= `LMT_RST_GEN_SEED;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata = r_reg.rdata;
  assign o_line_data = r_reg.line_data;
  assign o_line_strobe = r_reg.line_strobe;
  assign o_rx_data = r_reg.rx_data;
  assign o_rx_strobe = r_reg.rx_strobe;
  assign o_violation_flag_pin = r_reg.viol_pin;
  // sync flag uses an enable; second group uses masks
  assign o_irq = (r_reg.irq0[`LMT_IRQ0_SEQUENCE_SYNC] & r_reg.mask0[`LMT_IRQ0_SEQUENCE_SYNC]) |
    (|(r_reg.irq1[2:0] & ~r_reg.mask1[2:0]));

endmodule : lmt_line_maint

/* File: sim/lmt_line_maint_checker.sv */
// Port-level assertions of the line maintenance block
`timescale 1ns/1ps
module lmt_line_maint_checker import lmt_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire lmt_hw_pins_s i_hw,
  input wire logic o_line_data,
  input wire logic o_line_strobe,
  input wire logic o_rx_strobe,
  input wire logic o_rx_data,
  input wire logic o_violation_flag_pin,
  input wire logic o_irq
);
  // ------
  // Sequence history
  // ------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [14:0] hist_reg;
  logic [4:0] run_reg;
  wire logic prbs_hw = i_hw.hw_mode && i_hw.pattern_select == 2'h2;
  wire logic dig_hw = i_hw.hw_mode && i_hw.loop_select_pins == 2'h2;
  // Skip the first bits: pin changes need a few cycles to act
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist_reg <= 15'h0000;
      run_reg <= 5'h00;
    end else if (!prbs_hw) begin
      run_reg <= 5'h00;
    end else if (o_line_strobe) begin
      hist_reg <= {hist_reg[13:0], o_line_data};
      run_reg <= (run_reg == 5'h1F) ? run_reg : run_reg + 5'h01;
    end
  end
  strobe_pulse_a: assert property (o_line_strobe |=> !o_line_strobe)
    else $error("line strobe longer than one cycle");
  prbs_recur_a: assert property (
    prbs_hw && run_reg >= 5'h14 && o_line_strobe |-> o_line_data == (hist_reg[13] ^ hist_reg[14]))
    else $error("sequence bit breaks the feedback relation");
  ones_hw_a: assert property (
    (i_hw.hw_mode && i_hw.pattern_select == 2'h1) [*5] ##0 o_line_strobe |-> o_line_data)
    else $error("zero sent while all ones selected");
  viol_width_a: assert property ($rose(o_violation_flag_pin) |-> o_violation_flag_pin [*4])
    else $error("violation pin pulse too short");
  viol_rail_a: assert property ((!i_hw.single_rail) [*8] |-> !o_violation_flag_pin)
    else $error("violation pin high in dual rail");
  loop_digital_a: assert property (
    dig_hw [*6] ##0 o_line_strobe |-> o_rx_strobe && o_rx_data == o_line_data)
    else $error("looped bit missing on receive side");
  rst_quiet_a: assert property ($rose(i_rst_n) |-> !o_irq && !o_line_strobe && !o_rx_strobe)
    else $error("output active at reset release");
  rx_pulse_a: assert property (o_rx_strobe |=> !o_rx_strobe)
    else $error("receive strobe longer than one cycle");
  cover property (o_violation_flag_pin);
  cover property (o_irq);
  cover property (o_rx_strobe && dig_hw);
endmodule : lmt_line_maint_checker

/* File: sim/lmt_line_partner.sv */
// Far side model: framer source, master oscillator and AMI line loop
`timescale 1ns/1ps
module lmt_line_partner import lmt_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_line_data,
  input wire logic i_line_strobe,
  input wire logic i_bad,
  output lmt_tx_in_s o_tx,
  output lmt_rx_line_s o_rx,
  output logic o_mclk
);
  // ------
  // Clocks and line
  // ------
  logic [2:0] tx_ph_reg;
  logic [3:0] mclk_ph_reg;
  logic [2:0] rx_ph_reg;
  logic tx_bit_reg;
  logic mark_reg;
  logic pol_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_ph_reg <= 3'h0;
      mclk_ph_reg <= 4'h0;
      rx_ph_reg <= 3'h0;
      tx_bit_reg <= 1'b0;
      mark_reg <= 1'b0;
      pol_reg <= 1'b0;
    end else begin
      tx_ph_reg <= tx_ph_reg + 3'h1;
      mclk_ph_reg <= (mclk_ph_reg == 4'h9) ? 4'h0 : mclk_ph_reg + 4'h1;
      // Data moves at the falling edge, half a period clear of the rising edge
      if (tx_ph_reg == 3'h7) tx_bit_reg <= ~tx_bit_reg;
      rx_ph_reg <= (rx_ph_reg == 3'h0) ? 3'h0 : rx_ph_reg - 3'h1;
      if (i_line_strobe) begin
        rx_ph_reg <= 3'h7;
        mark_reg <= i_line_data;
        if (i_line_data && !i_bad) pol_reg <= ~pol_reg;
      end
    end
  end
  // Receive clock only runs while bits arrive
  assign o_rx = '{clk: rx_ph_reg[2], pos: rx_ph_reg[2] && mark_reg && pol_reg,
                  neg: rx_ph_reg[2] && mark_reg && !pol_reg};
  assign o_tx = '{clk: tx_ph_reg[2], data: tx_bit_reg};
  assign o_mclk = mclk_ph_reg >= 4'h5;
endmodule : lmt_line_partner

/* File: sim/lmt_line_maint_tb.sv */
// Self-checking testbench of the line maintenance block
`timescale 1ns/1ps
module lmt_line_maint_tb import lmt_pkg::*; ;
  // ------
  // Harness
  // ------
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic bad = 1'b0;
  lmt_hw_pins_s hw = 7'h02;
  lmt_reg_req_s req = '0;
  lmt_tx_in_s tx;
  lmt_rx_line_s rxl;
  logic mclk, line_data, line_strobe, rx_data, rx_strobe, viol, irq;
  logic viol_q = 1'b0;
  logic [7:0] rdata;
  logic [4:0] offs [12] = '{5'h1A, 5'h19, 5'h17, 5'h1B, 5'h1C, 5'h0D, 5'h0E, 5'h13,
                            5'h14, 5'h15, 5'h16, 5'h00};
  int fail_count = 0;
  int samples_checked = 0;
  int viol_rises = 0;
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    viol_q <= viol;
    if (viol && !viol_q) viol_rises++;
  end
  lmt_line_maint #(.P_SECOND_CYCLES(200)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_master_clock(mclk), .i_tx(tx), .i_rx_line(rxl),
    .i_hw(hw), .i_reg(req), .o_reg_rdata(rdata), .o_line_data(line_data),
    .o_line_strobe(line_strobe), .o_rx_data(rx_data), .o_rx_strobe(rx_strobe),
    .o_violation_flag_pin(viol), .o_irq(irq));
  lmt_line_partner u_partner (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_line_data(line_data),
    .i_line_strobe(line_strobe), .i_bad(bad), .o_tx(tx), .o_rx(rxl), .o_mclk(mclk));
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge i_clk);
    req.wr <= 1'b0;
    // Idle edge: wr is never set twice in one step, and a transfer settles
    @(posedge i_clk);
  endtask : reg_wr
  task automatic reg_rd(input logic [4:0] a, input logic [7:0] exp);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge i_clk);
    req.rd <= 1'b0;
    @(posedge i_clk);
    check($sformatf("reg %h", a), rdata, exp);
  endtask : reg_rd
  task automatic next_strobe;
    repeat (50) begin
      @(posedge i_clk);
      if (line_strobe === 1'b1) return;
    end
    check("line strobe wait", 8'h00, 8'h01);
    end_sim();
  endtask : next_strobe
  task automatic inject;
    next_strobe();
    bad <= 1'b1;
    next_strobe();
    bad <= 1'b0;
  endtask : inject
  // ------
  // Scenarios
  // ------
  initial begin
    logic d0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    foreach (offs[i]) reg_rd(offs[i], 8'h00);
    reg_wr(5'h10, 8'hFF);
    reg_rd(5'h10, 8'h00);
    reg_wr(5'h15, 8'h07);
    reg_rd(5'h15, 8'h07);
    reg_wr(5'h15, 8'h00);
    next_strobe();
    d0 = line_data;
    next_strobe();
    check("normal data", {7'h00, line_data}, {7'h00, ~d0});
    // Inverted sequence looped over the line until in step
    reg_wr(5'h14, 8'h01);
    reg_wr(5'h0D, 8'h0A);
    repeat (3000) @(posedge i_clk);
    reg_rd(5'h17, 8'h01);
    check("irq", {7'h00, irq}, 8'h01);
    reg_rd(5'h19, 8'h01);
    reg_rd(5'h19, 8'h00);
    reg_wr(5'h16, 8'h01);
    reg_wr(5'h0D, 8'h01);
    repeat (1000) @(posedge i_clk);
    reg_rd(5'h17, 8'h00);
    reg_rd(5'h19, 8'h01);
    // Violations on all ones, manual transfer
    reg_wr(5'h14, 8'h00);
    reg_wr(5'h13, 8'h01);
    reg_wr(5'h13, 8'h09);
    reg_wr(5'h13, 8'h01);
    reg_rd(5'h1A, 8'h01);
    repeat (3) inject();
    repeat (20) @(posedge i_clk);
    reg_wr(5'h13, 8'h09);
    reg_rd(5'h1B, 8'h03);
    reg_rd(5'h1C, 8'h00);
    reg_rd(5'h1A, 8'h01);
    check("violation pulses", viol_rises[7:0], 8'h03);
    // All zeros on master clock, one long run
    reg_wr(5'h0D, 8'h04);
    reg_wr(5'h13, 8'h02);
    reg_wr(5'h13, 8'h0A);
    reg_wr(5'h13, 8'h02);
    next_strobe();
    next_strobe();
    check("zeros", {7'h00, line_data}, 8'h00);
    repeat (600) @(posedge i_clk);
    reg_wr(5'h13, 8'h0A);
    reg_rd(5'h1B, 8'h01);
    reg_rd(5'h1A, 8'h01);
    // Automatic one-second reporting
    reg_wr(5'h13, 8'h05);
    repeat (205) @(posedge i_clk);
    check("irq", {7'h00, irq}, 8'h01);
    reg_rd(5'h1A, 8'h04);
    check("irq", {7'h00, irq}, 8'h00);
    reg_wr(5'h15, 8'h04);
    repeat (200) @(posedge i_clk);
    check("irq", {7'h00, irq}, 8'h00);
    reg_rd(5'h1A, 8'h04);
    reg_rd(5'h1B, 8'h00);
    // Pin control: sequence with digital loop, then all ones
    hw <= 7'h68;
    repeat (600) @(posedge i_clk);
    hw <= 7'h50;
    repeat (200) @(posedge i_clk);
    next_strobe();
    check("pin ones", {7'h00, line_data}, 8'h01);
    end_sim();
  end
endmodule : lmt_line_maint_tb

bind lmt_line_maint lmt_line_maint_checker u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hw(i_hw), .o_line_data(o_line_data),
  .o_line_strobe(o_line_strobe), .o_rx_strobe(o_rx_strobe), .o_rx_data(o_rx_data),
  .o_violation_flag_pin(o_violation_flag_pin), .o_irq(o_irq));
